/* hw/nrss_cfg.svh */
`ifndef NRSS_CFG_SVH
`define NRSS_CFG_SVH

// Operation select field of the first byte.
`define NRSS_MODE_REG_WR 2'h0
`define NRSS_MODE_REG_RD 2'h1
`define NRSS_MODE_FIFO 2'h2
`define NRSS_MODE_CMD 2'h3
`define NRSS_FIELD_FLOAD 6'h00
`define NRSS_FIELD_FREAD 6'h3F
`define NRSS_LAST_BIT 3'h7

// Register map of the bus slave, byte addresses.
`define NRSS_CTRL_OFS 8'h00
`define NRSS_STAT_OFS 8'h04
`define NRSS_CTRL_RST 32'h0000_0000
`define NRSS_CTRL_PDA_BIT 0
`define NRSS_CTRL_PDB_BIT 1
`define NRSS_CTRL_OPEN_BIT 7
`define NRSS_STAT_XTAL_BIT 0
`define NRSS_STAT_BUSY_BIT 1
`define NRSS_STAT_IRQ_BIT 2
`define NRSS_STAT_CMD_LSB 8

`define NRSS_HTRANS_NONSEQ 2'h2
`define NRSS_SYNC_WIDTH 4

`endif

/* hw/nrss_pkg.sv */
package nrss_pkg;

    typedef enum logic [2:0] {
        st_hdr,
        st_reg_wr,
        st_reg_rd,
        st_fifo_load,
        st_fifo_read,
        st_skip
    } nrss_state_t;

endpackage

/* hw/nrss_sync.sv */
`timescale 1ns/10ps
`include "nrss_cfg.svh"

module nrss_sync (
    input wire logic i_clock, // Core clock.
    input wire logic i_arst_n, // Asynchronous reset, active low.
    input wire logic [`NRSS_SYNC_WIDTH-1:0] i_async, // Levels from outside the clock domain.
    output logic [`NRSS_SYNC_WIDTH-1:0] o_sync // Synchronised levels.
);

    logic [`NRSS_SYNC_WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

/* hw/nrss_top.sv */
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "nrss_cfg.svh"


module nrss_top (
    input wire logic i_clock, // Core clock, 200 MHz.
    input wire logic i_arst_n, // Asynchronous reset, active low.
    input wire logic i_ss_n, // Serial select pin, active low.
    input wire logic i_sclk, // Serial clock pin.
    input wire logic i_mosi, // Serial data input pin.
    output logic o_miso, // Serial data output.
    output logic o_miso_oe, // Serial output drive enable.
    output logic o_miso_pd, // Output pull-down enable.
    input wire logic i_xtal_stable, // Crystal oscillator stable, asynchronous.
    output logic [5:0] o_reg_addr, // Register address for lookup.
    input wire logic i_reg_exists, // A register exists at o_reg_addr.
    input wire logic i_reg_readonly, // The register at o_reg_addr is read-only.
    input wire logic [7:0] i_reg_rdata, // Register contents at o_reg_addr.
    output logic o_reg_we, // Register write strobe.
    output logic [5:0] o_reg_waddr, // Register write address.
    output logic [7:0] o_reg_wdata, // Register write data.
    output logic o_fifo_push, // FIFO push strobe.
    output logic [7:0] o_fifo_wdata, // FIFO push data.
    input wire logic i_fifo_full, // FIFO full.
    output logic o_fifo_pop, // FIFO pop strobe.
    input wire logic [7:0] i_fifo_rdata, // FIFO head byte.
    input wire logic i_fifo_empty, // FIFO empty.
    output logic o_fifo_irq_hold, // Suppress FIFO level interrupts.
    output logic o_cmd_stb, // Direct command strobe.
    output logic [5:0] o_cmd_code, // Direct command code.
    input wire logic i_cmd_done, // Long command finished, one-cycle pulse.
    output logic o_irq, // Command completion interrupt.
    input wire logic i_hsel, // AHB slave select.
    input wire logic [31:0] i_haddr, // AHB address.
    input wire logic [1:0] i_htrans, // AHB transfer type.
    input wire logic i_hwrite, // AHB write.
    input wire logic [2:0] i_hsize, // AHB size.
    input wire logic [31:0] i_hwdata, // AHB write data.
    input wire logic i_hready, // AHB bus ready.
    output logic [31:0] o_hrdata, // AHB read data.
    output logic o_hreadyout, // AHB slave ready.
    output logic o_hresp // AHB response.
);

    function automatic logic is_read(input nrss_pkg::nrss_state_t s);
        is_read = (s == nrss_pkg::st_reg_rd) || (s == nrss_pkg::st_fifo_read);
    endfunction

    logic [`NRSS_SYNC_WIDTH-1:0] sync_w;
    logic ss_s;
    logic sclk_s;
    logic mosi_s;
    logic xtal_s;
    logic sclk_prev_q;
    nrss_pkg::nrss_state_t state_q;
    nrss_pkg::nrss_state_t state_d;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic load_q;
    logic [31:0] ctrl_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;

    // Select passes the synchroniser inverted, so its cleared state reads as deselected.
    nrss_sync u_sync (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_async({i_xtal_stable, i_mosi, i_sclk, !i_ss_n}),
        .o_sync(sync_w)
    );

    assign ss_s = !sync_w[0];
    assign sclk_s = sync_w[1];
    assign mosi_s = sync_w[2];
    assign xtal_s = sync_w[3];

    wire fall_w = sclk_prev_q && !sclk_s;
    wire rise_w = !sclk_prev_q && sclk_s;
    wire byte_done_w = !ss_s && fall_w && (bit_cnt_q == `NRSS_LAST_BIT);
    wire [7:0] rx_byte_w = {rx_q[6:0], mosi_s};
    wire [1:0] mode_w = rx_byte_w[7:6];
    wire [5:0] field_w = rx_byte_w[5:0];
    wire fifo_ok_w = ctrl_q[`NRSS_CTRL_OPEN_BIT] && xtal_s;
    wire hdr_done_w = byte_done_w && (state_q == nrss_pkg::st_hdr);
    wire wr_ok_w = i_reg_exists && !i_reg_readonly;
    wire irq_clr_w = wr_pend_q && (wr_addr_q == `NRSS_STAT_OFS) && i_hwdata[`NRSS_STAT_IRQ_BIT];
    // An empty FIFO or an absent register reads as zeros, and nothing is popped for them.
    wire [7:0] tx_src_w = (state_q == nrss_pkg::st_fifo_read) ? (i_fifo_empty ? 8'h00 : i_fifo_rdata) :
                          (i_reg_exists ? i_reg_rdata : 8'h00);
    // The shift register reloads two clocks after a byte ends, three after a FIFO read byte, well before the next rising edge.
    wire load_d = (hdr_done_w && is_read(state_d)) ||
                  (byte_done_w && (state_q == nrss_pkg::st_reg_rd)) || o_fifo_pop;
    wire pop_d = byte_done_w && (state_q == nrss_pkg::st_fifo_read) && !i_fifo_empty;
    wire oe_d = !ss_s && (o_miso_oe || (rise_w && is_read(state_q)));

    // A direct command drops straight back to header decode, so that another
    // operation can follow it without a deselect.
    always_comb begin
        state_d = state_q;
        if (ss_s) begin
            state_d = nrss_pkg::st_hdr;
        end else if (hdr_done_w) begin
            case (mode_w)
                `NRSS_MODE_REG_WR: begin
                    state_d = nrss_pkg::st_reg_wr;
                end
                `NRSS_MODE_REG_RD: begin
                    state_d = nrss_pkg::st_reg_rd;
                end
                `NRSS_MODE_FIFO: begin
                    if (fifo_ok_w && field_w == `NRSS_FIELD_FLOAD) begin
                        state_d = nrss_pkg::st_fifo_load;
                    end else if (fifo_ok_w && field_w == `NRSS_FIELD_FREAD) begin
                        state_d = nrss_pkg::st_fifo_read;
                    end else begin
                        state_d = nrss_pkg::st_skip;
                    end
                end
                default: begin
                    state_d = nrss_pkg::st_hdr;
                end
            endcase
        end
    end

    // Byte framing: bits counted and shifted in on falling serial clock edges.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sclk_prev_q <= 1'b0;
            state_q <= nrss_pkg::st_hdr;
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
        end else begin
            sclk_prev_q <= sclk_s;
            state_q <= state_d;
            if (ss_s) begin
                bit_cnt_q <= 3'h0;
            end else if (fall_w) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                rx_q <= rx_byte_w;
            end
        end
    end

    // Register address, auto-increment and write commit.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_addr <= 6'h00;
            o_reg_we <= 1'b0;
            o_reg_waddr <= 6'h00;
            o_reg_wdata <= 8'h00;
        end else begin
            o_reg_we <= 1'b0;
            if (hdr_done_w) begin
                o_reg_addr <= field_w;
            end else if (byte_done_w && (state_q == nrss_pkg::st_reg_wr || state_q == nrss_pkg::st_reg_rd)) begin
                o_reg_addr <= o_reg_addr + 6'h01;
                o_reg_we <= (state_q == nrss_pkg::st_reg_wr) && wr_ok_w;
                o_reg_waddr <= o_reg_addr;
                o_reg_wdata <= rx_byte_w;
            end
        end
    end

    // FIFO traffic and direct commands.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fifo_push <= 1'b0;
            o_fifo_wdata <= 8'h00;
            o_fifo_pop <= 1'b0;
            o_fifo_irq_hold <= 1'b0;
            o_cmd_stb <= 1'b0;
            o_cmd_code <= 6'h00;
            o_irq <= 1'b0;
        end else begin
            o_fifo_push <= byte_done_w && (state_q == nrss_pkg::st_fifo_load) && !i_fifo_full;
            if (byte_done_w && state_q == nrss_pkg::st_fifo_load) begin
                o_fifo_wdata <= rx_byte_w;
            end
            o_fifo_pop <= pop_d;
            o_fifo_irq_hold <= state_d == nrss_pkg::st_fifo_load || state_d == nrss_pkg::st_fifo_read;
            o_cmd_stb <= hdr_done_w && (mode_w == `NRSS_MODE_CMD);
            if (hdr_done_w && mode_w == `NRSS_MODE_CMD) begin
                o_cmd_code <= field_w;
            end
            // A completion in the same cycle as a clear wins, so no interrupt is lost.
            if (i_cmd_done) begin
                o_irq <= 1'b1;
            end else if (irq_clr_w) begin
                o_irq <= 1'b0;
            end
        end
    end

    // Read data: loaded between bytes, driven out on rising serial clock edges.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            load_q <= 1'b0;
            tx_q <= 8'h00;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
            o_miso_pd <= 1'b0;
        end else begin
            load_q <= load_d;
            if (load_q) begin
                tx_q <= tx_src_w;
            end else if (!ss_s && rise_w && is_read(state_q)) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (ss_s) begin
                o_miso <= 1'b0;
            end else if (rise_w && is_read(state_q)) begin
                o_miso <= tx_q[7];
            end
            o_miso_oe <= oe_d;
            o_miso_pd <= !oe_d && ctrl_q[`NRSS_CTRL_PDA_BIT] && ctrl_q[`NRSS_CTRL_PDB_BIT];
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY, unmapped words read zero.
    wire addr_ph_w = i_hsel && i_hready && (i_htrans == `NRSS_HTRANS_NONSEQ);
    wire [31:0] stat_w = {16'h0000, 2'h0, o_cmd_code, 5'h00, o_irq, (state_q != nrss_pkg::st_hdr), xtal_s};
    wire [31:0] rd_mux_w = (i_haddr[7:0] == `NRSS_CTRL_OFS) ? ctrl_q :
                           (i_haddr[7:0] == `NRSS_STAT_OFS) ? stat_w : 32'h0000_0000;
    wire mapped_w = i_haddr[31:8] == 24'h000000;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            ctrl_q <= `NRSS_CTRL_RST;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            wr_pend_q <= addr_ph_w && i_hwrite && mapped_w;
            if (addr_ph_w) begin
                wr_addr_q <= i_haddr[7:0];
                o_hrdata <= (!i_hwrite && mapped_w) ? rd_mux_w : 32'h0000_0000;
            end
            if (wr_pend_q && wr_addr_q == `NRSS_CTRL_OFS) begin
                ctrl_q <= {24'h000000, i_hwdata[7], 4'h0, i_hwdata[2:0]};
            end
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_arst_n);

    select_reset_a: assert property (ss_s |=> state_q == nrss_pkg::st_hdr && bit_cnt_q == 3'h0)
        else $error("port not held in reset while select high");
    fall_count_a: assert property (!ss_s && fall_w |=> bit_cnt_q == $past(bit_cnt_q) + 3'h1)
        else $error("bit not counted on falling edge");
    write_commit_a: assert property (o_reg_we |-> $past(byte_done_w) && $past(state_q) == nrss_pkg::st_reg_wr)
        else $error("register write outside last bit of byte");
    write_guard_a: assert property (o_reg_we |-> $past(i_reg_exists) && !$past(i_reg_readonly))
        else $error("write to absent or read-only register");
    addr_incr_a: assert property (byte_done_w && state_q == nrss_pkg::st_reg_rd
        |=> o_reg_addr == $past(o_reg_addr) + 6'h01)
        else $error("register address not incremented");
    absent_zero_a: assert property (load_q && state_q == nrss_pkg::st_reg_rd && !i_reg_exists
        |=> tx_q == 8'h00)
        else $error("absent register read not zero");
    miso_edge_a: assert property (o_miso_oe && $past(o_miso_oe) && $changed(o_miso) |-> $past(rise_w))
        else $error("output bit changed off a rising edge");
    tristate_a: assert property (o_miso_oe |-> $past(is_read(state_q)) && !o_miso_pd)
        else $error("output driven outside read data");
    cmd_strobe_a: assert property (o_cmd_stb |-> $past(hdr_done_w) && $past(mode_w) == `NRSS_MODE_CMD)
        else $error("command strobe without command byte");
    fifo_gate_a: assert property (hdr_done_w && mode_w == `NRSS_MODE_FIFO && !fifo_ok_w
        |=> state_q == nrss_pkg::st_skip)
        else $error("FIFO operation while not enabled");
    fifo_push_a: assert property (o_fifo_push |-> $past(byte_done_w) && $past(state_q) == nrss_pkg::st_fifo_load)
        else $error("FIFO push without a whole byte");
    fifo_pop_a: assert property (o_fifo_pop |-> $past(byte_done_w) && $past(state_q) == nrss_pkg::st_fifo_read)
        else $error("FIFO pop before byte fully read");

    // Decode, framing and output checks.
    write_decode_a: assert property (hdr_done_w && mode_w == `NRSS_MODE_REG_WR
        |=> state_q == nrss_pkg::st_reg_wr)
        else $error("register write header not decoded");
    read_decode_a: assert property (hdr_done_w && mode_w == `NRSS_MODE_FIFO && fifo_ok_w
        && field_w == `NRSS_FIELD_FREAD |=> state_q == nrss_pkg::st_fifo_read)
        else $error("FIFO read header not decoded");
    fifo_persist_a: assert property (state_q == nrss_pkg::st_fifo_load && !ss_s
        |=> state_q == nrss_pkg::st_fifo_load)
        else $error("FIFO load mode left while select low");
    hold_release_a: assert property (ss_s |=> !o_fifo_irq_hold)
        else $error("FIFO interrupt hold kept after deselect");
    cut_byte_a: assert property (ss_s |=> !o_reg_we && !o_fifo_push && !o_fifo_pop)
        else $error("byte handed over while deselected");
    write_data_a: assert property (o_reg_we |-> o_reg_wdata == $past(rx_byte_w))
        else $error("register write data differs from received byte");
    push_data_a: assert property (o_fifo_push |-> o_fifo_wdata == $past(rx_byte_w))
        else $error("FIFO push data differs from received byte");
    chain_hdr_a: assert property (o_cmd_stb |-> state_q == nrss_pkg::st_hdr)
        else $error("no header decode after a direct command");
    irq_set_a: assert property (i_cmd_done |=> o_irq)
        else $error("command completion did not raise the interrupt");
    pulldown_a: assert property (o_miso_pd |-> !o_miso_oe && $past(ctrl_q[`NRSS_CTRL_PDA_BIT])
        && $past(ctrl_q[`NRSS_CTRL_PDB_BIT]))
        else $error("pull-down on while driving or not enabled");
    oe_drop_a: assert property (ss_s |=> !o_miso_oe)
        else $error("output still driven after deselect");
    pop_nonempty_a: assert property (o_fifo_pop |-> !$past(i_fifo_empty))
        else $error("FIFO popped while empty");

    reg_write_c: cover property (o_reg_we);
    reg_read_c: cover property (o_miso_oe && state_q == nrss_pkg::st_reg_rd);
    fifo_load_c: cover property (o_fifo_push);
    chain_c: cover property (o_cmd_stb ##[1:300] state_q == nrss_pkg::st_reg_rd);
    fifo_read_c: cover property (o_fifo_pop);

endmodule

/* verification/nrss_spi_master.sv */
`timescale 1ns/10ps

module nrss_spi_master (
    output logic o_ss_n, // Select, active low.
    output logic o_sclk, // Serial clock, idle low.
    output logic o_mosi, // Data to the device.
    input wire logic i_miso, // Data from the device.
    input wire logic i_miso_oe, // Device drives its output.
    input wire logic i_miso_pd, // Pull-down active on the output.
    output logic [7:0] o_rx_byte, // Last reported byte read back.
    output logic o_rx_tgl // Toggles once per reported byte.
);
    logic line;

    // A released output shows the pull-down, else the inverse of the level left behind.
    assign line = i_miso_oe ? i_miso : (i_miso_pd ? 1'h0 : ~i_miso);

    initial begin
        o_ss_n = 1'h1;
        o_sclk = 1'h0;
        o_mosi = 1'h0;
        o_rx_byte = 8'h00;
        o_rx_tgl = 1'h0;
    end

    task automatic sel();
        o_ss_n = 1'h0;
        #100;
    endtask

    task automatic desel();
        #300;
        o_ss_n = 1'h1;
        o_mosi = ~o_mosi;
        #200;
    endtask

    // Data changes 10 ns after a fall so the device keeps its hold time.
    task automatic xbyte(input logic [7:0] tx, input int nb, input bit rep);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            #10 o_mosi = tx[i];
            #22 o_sclk = 1'h1;
            #32 o_sclk = 1'h0;
            rx = {rx[6:0], line};
        end
        if (rep && nb == 8) begin
            o_rx_byte = rx;
            o_rx_tgl = ~o_rx_tgl;
        end
    endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/10ps
`include "nrss_cfg.svh"

module tb;
    logic i_clock = 1'h0;
    logic i_arst_n = 1'h0;
    logic i_hsel = 1'h0;
    logic i_hwrite = 1'h0;
    logic i_xtal_stable = 1'h0;
    logic i_cmd_done = 1'h0;
    logic [31:0] i_haddr = 32'h0;
    logic [31:0] i_hwdata = 32'h0;
    logic [1:0] i_htrans = 2'h0;
    logic o_miso, o_miso_oe, o_miso_pd, o_reg_we, o_fifo_push, o_fifo_pop, o_fifo_irq_hold;
    logic o_cmd_stb, o_irq, o_hreadyout, o_hresp, ss_n, sclk, mosi, rx_tgl;
    logic rx_seen = 1'h0;
    logic [5:0] o_reg_addr, o_reg_waddr, o_cmd_code, c;
    logic [7:0] o_reg_wdata, o_fifo_wdata, rx_byte;
    logic [31:0] o_hrdata, rd;
    logic [7:0] rf [0:63];
    logic [7:0] fm [0:127];
    logic [7:0] d [0:3];
    logic [6:0] wp = 7'h00;
    logic [6:0] rp = 7'h00;
    logic [15:0] exp_q [$];
    integer seed;
    int error_cnt = 0;
    int samples_checked = 0;

    nrss_top i_nrss_top (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_ss_n(ss_n), .i_sclk(sclk), .i_mosi(mosi),
        .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_miso_pd(o_miso_pd), .i_xtal_stable(i_xtal_stable),
        .o_reg_addr(o_reg_addr), .i_reg_exists(o_reg_addr < 6'h30), .i_reg_readonly(o_reg_addr == 6'h2F),
        .i_reg_rdata(rf[o_reg_addr]), .o_reg_we(o_reg_we), .o_reg_waddr(o_reg_waddr), .o_reg_wdata(o_reg_wdata),
        .o_fifo_push(o_fifo_push), .o_fifo_wdata(o_fifo_wdata), .i_fifo_full(7'(wp - rp) == 7'h60),
        .o_fifo_pop(o_fifo_pop), .i_fifo_rdata(fm[rp]), .i_fifo_empty(wp == rp), .o_fifo_irq_hold(o_fifo_irq_hold),
        .o_cmd_stb(o_cmd_stb), .o_cmd_code(o_cmd_code), .i_cmd_done(i_cmd_done), .o_irq(o_irq),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp));

    nrss_spi_master i_nrss_spi_master (.o_ss_n(ss_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(o_miso),
        .i_miso_oe(o_miso_oe), .i_miso_pd(o_miso_pd), .o_rx_byte(rx_byte), .o_rx_tgl(rx_tgl));

    initial begin
        forever #2.5 i_clock = ~i_clock;
    end

    // Core-side register file and FIFO stand-ins.
    always @(posedge i_clock) begin
        if (o_reg_we) rf[o_reg_waddr] <= o_reg_wdata;
        if (o_fifo_push) fm[wp] <= o_fifo_wdata;
        if (o_fifo_push) wp <= wp + 7'h01;
        if (o_fifo_pop) rp <= rp + 7'h01;
    end

    task automatic chk(input logic [31:0] act, input logic [31:0] e);
        samples_checked++;
        if (act !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, act, e);
        end
    endtask

    task automatic sb(input logic [15:0] act);
        chk(act, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFFFF);
    endtask

    always @(posedge i_clock) begin
        if (o_reg_we) sb({2'h0, o_reg_waddr, o_reg_wdata});
        if (o_fifo_push) sb({8'h40, o_fifo_wdata});
        if (o_cmd_stb) sb({2'h2, o_cmd_code, 8'h00});
        if (rx_tgl !== rx_seen) sb({8'hC0, rx_byte});
        rx_seen <= rx_tgl;
    end

    task automatic ex(input logic [15:0] v);
        exp_q.push_back(v);
    endtask

    task automatic tx(input logic [7:0] b, input int n, input bit r);
        i_nrss_spi_master.xbyte(b, n, r);
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] q);
        @(posedge i_clock);
        i_hsel <= 1'h1;
        i_htrans <= `NRSS_HTRANS_NONSEQ;
        i_haddr <= a;
        i_hwrite <= w;
        do @(posedge i_clock); while (o_hreadyout !== 1'h1);
        i_htrans <= 2'h0;
        i_hsel <= 1'h0;
        i_hwdata <= wd;
        do @(posedge i_clock); while (o_hreadyout !== 1'h1);
        q = o_hrdata;
        chk(o_hresp, 1'h0);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end

    initial begin
        seed = 32'h0adaa361;
        for (int i = 0; i < 64; i++) rf[i] = 8'(i) ^ 8'hA5;
        for (int i = 0; i < 4; i++) d[i] = 8'($random(seed));
        repeat (2) @(posedge i_clock);
        i_arst_n <= 1'h1;
        repeat (4) @(posedge i_clock);
        ahb(1'h0, `NRSS_CTRL_OFS, 32'h0, rd);
        chk(rd, `NRSS_CTRL_RST);
        ahb(1'h0, 32'h10, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'h1, `NRSS_CTRL_OFS, 32'h3, rd);
        repeat (6) @(posedge i_clock);
        chk(o_miso_pd, 1'h1);
        ahb(1'h1, `NRSS_CTRL_OFS, 32'h81, rd);
        repeat (6) @(posedge i_clock);
        chk(o_miso_pd, 1'h0);
        ahb(1'h1, `NRSS_CTRL_OFS, 32'h83, rd);
        @(negedge i_clock);
        i_nrss_spi_master.sel();
        tx(8'h03, 8, 0);
        ex({2'h0, 6'h03, d[0]});
        tx(d[0], 8, 0);
        ex({2'h0, 6'h04, d[1]});
        tx(d[1], 8, 0);
        chk(o_miso_oe, 1'h0);
        i_nrss_spi_master.desel();
        for (int i = 0; i < 3; i++) begin
            i_nrss_spi_master.sel();
            tx((i == 2) ? 8'h05 : ((i == 1) ? 8'h3F : 8'h2F), 8, 0);
            tx(8'h5A, (i == 2) ? 4 : 8, 0);
            i_nrss_spi_master.desel();
        end
        i_nrss_spi_master.sel();
        tx(8'h43, 8, 0);
        ex({8'hC0, d[0]});
        tx(8'h00, 8, 1);
        ex({8'hC0, d[1]});
        tx(8'h00, 8, 1);
        ex({8'hC0, 8'h05 ^ 8'hA5});
        tx(8'h00, 8, 1);
        i_nrss_spi_master.desel();
        chk(o_miso_oe, 1'h0);
        i_nrss_spi_master.sel();
        tx(8'h7F, 8, 0);
        ex(16'hC000);
        tx(8'h00, 8, 1);
        i_nrss_spi_master.desel();
        for (int i = 0; i < 4; i++) begin
            c = 6'(i * 21);
            i_nrss_spi_master.sel();
            ex({2'h2, c, 8'h00});
            tx({2'h3, c}, 8, 0);
            i_nrss_spi_master.desel();
        end
        i_nrss_spi_master.sel();
        ex({2'h2, 6'h2A, 8'h00});
        tx(8'hEA, 8, 0);
        tx(8'h06, 8, 0);
        ex({2'h0, 6'h06, d[2]});
        tx(d[2], 8, 0);
        i_nrss_spi_master.desel();
        i_nrss_spi_master.sel();
        tx(8'h80, 8, 0);
        tx(8'h11, 8, 0);
        i_nrss_spi_master.desel();
        @(posedge i_clock);
        i_xtal_stable <= 1'h1;
        @(negedge i_clock);
        i_nrss_spi_master.sel();
        tx(8'h95, 8, 0);
        tx(8'h12, 8, 0);
        i_nrss_spi_master.desel();
        i_nrss_spi_master.sel();
        tx(8'h80, 8, 0);
        for (int i = 0; i < 3; i++) begin
            ex({8'h40, d[i]});
            tx(d[i], 8, 0);
        end
        chk(o_fifo_irq_hold, 1'h1);
        tx(8'h77, 4, 0);
        i_nrss_spi_master.desel();
        chk(o_fifo_irq_hold, 1'h0);
        i_nrss_spi_master.sel();
        tx(8'hBF, 8, 0);
        ex({8'hC0, d[0]});
        tx(8'h00, 8, 1);
        tx(8'h00, 5, 0);
        i_nrss_spi_master.desel();
        i_nrss_spi_master.sel();
        tx(8'hBF, 8, 0);
        for (int i = 1; i < 4; i++) begin
            ex({8'hC0, (i < 3) ? d[i] : 8'h00});
            tx(8'h00, 8, 1);
        end
        i_nrss_spi_master.desel();
        @(posedge i_clock);
        i_cmd_done <= 1'h1;
        @(posedge i_clock);
        i_cmd_done <= 1'h0;
        ahb(1'h0, `NRSS_STAT_OFS, 32'h0, rd);
        chk(rd & 32'h3F07, 32'h2A05);
        ahb(1'h1, `NRSS_STAT_OFS, 32'h4, rd);
        repeat (3) @(posedge i_clock);
        chk(o_irq, 1'h0);
        repeat (20) @(posedge i_clock);
        chk(exp_q.size(), 32'h0);
        end_sim();
    end
endmodule
